//--- hdl/fdsp_top.sv
// full duplex serial port: control register, receiver, line pins
// assumes the cpu register bus and timer overflow pulses run on clk_i
//
// Notes on behaviour
// - async modes transmit and receive concurrently; overrun loses one byte
// - data writes load transmitter, reads give receive buffer
// - shift mode: data on rxd, clock on txd
// - 8-bit mode: start, eight data, stop frame
// - 9-bit mode: ninth bit from control register
// - fixed 9-bit rate: clock/64 or clock/32
// - variable 9-bit mode same framing, timer rate
// - data write starts transmission in every mode
// - shift receive starts when flag clear, enabled and transmitter idle
// - async receive starts on start bit if enabled
// - bits 7 and 6 select the mode
// - multiprocessor: ninth bit zero suppresses receive flag
// - multiprocessor in 8-bit mode needs valid stop
// - bit 4 enables reception, software only
// - bit 3 is the transmitted ninth bit
// - bit 2 holds received ninth or stop bit
// - transmit flag at eighth bit end or stop
// - receive flag at eighth bit end or mid-stop
// - receive and transmit clocks chosen independently
// - per-direction select: timer 2 set, timer 1 clear
// - timer 2 baud is overflow rate over 16
// - double-rate bit doubles timer 1 and fixed rates
`timescale 1ns/1ps
module fdsp_top import fdsp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // cpu register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // baud sources
   input wire logic t1_ovf_i,
   input wire logic t2_ovf_i,
   input wire logic double_rate_bit_i,
   input wire logic rx_clock_source_select_i,
   input wire logic tx_clock_source_select_i,
   // flags toward the interrupt logic
   output logic tx_complete_flag_o,
   output logic rx_complete_flag_o,
   // line pins
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_n_o,
   output logic txd_o
);
   fdsp_tick_if tk ();

   logic [1:0] mode_q;
   logic mpe_q;
   logic ren_q;
   logic tb8_q;
   logic rb8_q;
   logic ti_q;
   logic ri_q;
   logic [7:0] rxbuf_q;
   logic [7:0] rdata_q;
   logic wr_serial_control_status;
   logic wr_serial_data_location;
   logic [7:0] serial_control_status_rd;
   logic tx_line;
   logic tx_low;
   logic tx_busy;
   logic ti_set;
   logic rx_s1_q;
   logic rx_s2_q;
   logic rx_s3_q;
   logic rx_lvl_q;
   logic rx_prev_q;
   logic rx_fall;
   fdsp_rx_state_t st_q;
   logic [3:0] os_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic [1:0] vote_q;
   logic low_q;
   logic maj;
   logic rx_fin;
   logic m0_fin;
   logic nine_rx;
   logic [7:0] fin_data;
   logic fin_ninth;
   logic accept;
   logic ri_set;
   logic m0;
   logic m0_go;

   function automatic logic vote3(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction

   assign m0 = (mode_q == MODE_SHIFT);

   // ----------------------------------------
   // register access
   // ----------------------------------------
   assign wr_serial_control_status = sfr_wr_i && (sfr_addr_i == SERIAL_CONTROL_STATUS_ADDR);
   assign wr_serial_data_location = sfr_wr_i && (sfr_addr_i == SERIAL_DATA_LOCATION_ADDR);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_q <= SERIAL_CONTROL_STATUS_RESET[B_SM0:B_SM1];
         mpe_q <= SERIAL_CONTROL_STATUS_RESET[B_MPE];
         ren_q <= SERIAL_CONTROL_STATUS_RESET[B_REN];
         tb8_q <= SERIAL_CONTROL_STATUS_RESET[B_TB8];
      end else if (wr_serial_control_status) begin
         mode_q <= sfr_wdata_i[B_SM0:B_SM1];
         mpe_q <= sfr_wdata_i[B_MPE];
         ren_q <= sfr_wdata_i[B_REN];
         tb8_q <= sfr_wdata_i[B_TB8];
      end
   end

   // hardware set wins over a software write in the same cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ti_q <= SERIAL_CONTROL_STATUS_RESET[B_TI];
      end else if (ti_set) begin
         ti_q <= 1'b1;
      end else if (wr_serial_control_status) begin
         ti_q <= sfr_wdata_i[B_TI];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ri_q <= SERIAL_CONTROL_STATUS_RESET[B_RI];
      end else if (ri_set) begin
         ri_q <= 1'b1;
      end else if (wr_serial_control_status) begin
         ri_q <= sfr_wdata_i[B_RI];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rb8_q <= SERIAL_CONTROL_STATUS_RESET[B_RB8];
      end else if (rx_fin && accept) begin
         rb8_q <= fin_ninth;
      end else if (wr_serial_control_status) begin
         rb8_q <= sfr_wdata_i[B_RB8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rxbuf_q <= '0;
      end else if (ri_set) begin
         rxbuf_q <= m0_fin ? {rx_lvl_q, sh_q[8:2]} : fin_data;
      end
   end

   assign serial_control_status_rd = {mode_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= RD_NONE;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            SERIAL_CONTROL_STATUS_ADDR: rdata_q <= serial_control_status_rd;
            SERIAL_DATA_LOCATION_ADDR: rdata_q <= rxbuf_q;
            default: rdata_q <= RD_NONE;
         endcase
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign tx_complete_flag_o = ti_q;
   assign rx_complete_flag_o = ri_q;

   // ----------------------------------------
   // rate generator and transmitter
   // ----------------------------------------
   fdsp_baud u_baud (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .mode_i(mode_q),
      .double_rate_i(double_rate_bit_i),
      .rx_src_t2_i(rx_clock_source_select_i),
      .tx_src_t2_i(tx_clock_source_select_i),
      .t1_ovf_i(t1_ovf_i),
      .t2_ovf_i(t2_ovf_i),
      .tk(tk)
   );

   // transmitter runs independently of the receiver
   fdsp_tx u_tx (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .tk(tk),
      .mode_i(mode_q),
      .start_i(wr_serial_data_location),
      .data_i(sfr_wdata_i),
      .ninth_i(tb8_q),
      .line_o(tx_line),
      .m0_clk_low_o(tx_low),
      .busy_o(tx_busy),
      .ti_set_o(ti_set)
   );

   // ----------------------------------------
   // line input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end else begin
         rx_s1_q <= rxd_i;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_lvl_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         if (rx_s2_q == rx_s3_q) begin
            rx_lvl_q <= rx_s3_q;
         end
         rx_prev_q <= rx_lvl_q;
      end
   end
   assign rx_fall = rx_prev_q && !rx_lvl_q;

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   assign maj = vote3(vote_q[1], vote_q[0], rx_lvl_q);
   assign nine_rx = is_nine(mode_q);
   assign rx_fin = (st_q == RX_ASYNC) && tk.rx_os && (os_q == OS_S3)
      && (bit_q == stop_idx(mode_q));
   assign m0_fin = (st_q == RX_SHIFT) && tk.m0_rise && low_q && (bit_q == BIT_LAST8);
   assign fin_data = nine_rx ? sh_q[7:0] : sh_q[8:1];
   // stop bit stands in for the ninth bit in 8-bit mode
   assign fin_ninth = nine_rx ? sh_q[8] : maj;
   // a full buffer drops the new byte; flag filter for multiprocessor use
   assign accept = !ri_q && (!mpe_q || fin_ninth);
   assign ri_set = (rx_fin && accept) || m0_fin;
   // shift-mode reception waits for an idle transmitter
   assign m0_go = m0 && ren_q && !ri_q && !tx_busy && !wr_serial_data_location;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q <= RX_IDLE;
         os_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         vote_q <= '0;
         low_q <= 1'b0;
      end else begin
         case (st_q)
            RX_IDLE: begin
               os_q <= '0;
               bit_q <= '0;
               low_q <= 1'b0;
               if (m0_go) begin
                  st_q <= RX_SHIFT;
               end else if (!m0 && ren_q && rx_fall) begin
                  st_q <= RX_ASYNC;
               end
            end
            RX_ASYNC: begin
               if (tk.rx_os) begin
                  os_q <= os_q + 4'h1;
                  if (os_q >= OS_S1 && os_q < OS_S3) begin
                     vote_q <= {vote_q[0], rx_lvl_q};
                  end
                  if (os_q == OS_S3) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == '0 && maj) begin
                        st_q <= RX_IDLE;
                     end else if (bit_q == stop_idx(mode_q)) begin
                        st_q <= RX_IDLE;
                     end else if (bit_q != '0) begin
                        sh_q <= {maj, sh_q[8:1]};
                     end
                  end
               end
            end
            RX_SHIFT: begin
               if (tk.m0_fall) begin
                  low_q <= 1'b1;
               end else if (tk.m0_rise && low_q) begin
                  low_q <= 1'b0;
                  sh_q <= {rx_lvl_q, sh_q[8:1]};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == BIT_LAST8) begin
                     st_q <= RX_IDLE;
                  end
               end
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   // shift mode: txd is the shift clock, idle high
   assign txd_o = m0 ? !(tx_low || low_q) : tx_line;
   assign rxd_o = tx_line;
   assign rxd_oe_n_o = !(m0 && tx_busy);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   ri_set_wins_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ri_set && wr_serial_control_status && !sfr_wdata_i[B_RI] |=> ri_q)
      else $error("receive flag clear beat a completion");
   overrun_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rx_fin && ri_q && !wr_serial_control_status |=> $stable(rxbuf_q) && ri_q)
      else $error("overrun replaced the unread byte");
   mpe_filter_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rx_fin && mpe_q && nine_rx && !sh_q[8] && !ri_q && !wr_serial_control_status |=> !ri_q)
      else $error("address filter let a data frame through");
   ren_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st_q == RX_IDLE && !ren_q |=> st_q == RX_IDLE)
      else $error("reception started while disabled");
   shift_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st_q == RX_IDLE && m0_go |=> st_q == RX_SHIFT)
      else $error("shift mode reception did not start");
   serial_data_location_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sfr_rd_i && sfr_addr_i == SERIAL_DATA_LOCATION_ADDR |=> sfr_rdata_o == $past(rxbuf_q))
      else $error("data read did not return the receive buffer");
   tx_launch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_serial_data_location |=> tx_busy [*2])
      else $error("data write did not start a transmission");
   shift_clk_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      m0 && !tx_busy && st_q == RX_IDLE && !$past(tx_busy) |-> txd_o)
      else $error("shift clock active with nothing to shift");
endmodule

//--- hdl/fdsp_pkg.sv
// shared constants of the full duplex serial port
// assumes one system clock; register addresses are on the cpu register bus
package fdsp_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR = 8'h98;
   localparam logic [7:0] SERIAL_DATA_LOCATION_ADDR = 8'h99;
   localparam logic [7:0] SERIAL_CONTROL_STATUS_RESET = 8'h00;
   localparam logic [7:0] RD_NONE = 8'h00;
   localparam int B_SM0 = 7;
   localparam int B_SM1 = 6;
   localparam int B_MPE = 5;
   localparam int B_REN = 4;
   localparam int B_TB8 = 3;
   localparam int B_RB8 = 2;
   localparam int B_TI = 1;
   localparam int B_RI = 0;
   // ----------------------------------------
   // modes and timing
   // ----------------------------------------
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_VAR8 = 2'h1;
   localparam logic [1:0] MODE_FIX9 = 2'h2;
   localparam logic [1:0] MODE_VAR9 = 2'h3;
   localparam logic [3:0] SHIFT_LAST = 4'hb;
   localparam logic [3:0] SHIFT_HALF = 4'h6;
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] OS_S1 = 4'h7;
   localparam logic [3:0] OS_S3 = 4'h9;
   localparam logic [3:0] BIT_LAST8 = 4'h7;
   localparam logic [3:0] STOP_IDX8 = 4'h9;
   localparam logic [3:0] STOP_IDX9 = 4'ha;
   localparam logic [1:0] PRE_SLOW = 2'h3;

   typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SHIFT} fdsp_rx_state_t;

   function automatic logic is_nine(input logic [1:0] m);
      return m[1];
   endfunction

   function automatic logic [3:0] stop_idx(input logic [1:0] m);
      return is_nine(m) ? STOP_IDX9 : STOP_IDX8;
   endfunction
endpackage

//--- hdl/fdsp_tick_if.sv
// timing enables from the rate generator to the shifters
// assumes all users run on the same system clock
`timescale 1ns/1ps
interface fdsp_tick_if;
   logic m0_fall;
   logic m0_rise;
   logic rx_os;
   logic tx_os;
   modport src (output m0_fall, output m0_rise, output rx_os, output tx_os);
   modport snk (input m0_fall, input m0_rise, input rx_os, input tx_os);
endinterface

//--- hdl/fdsp_baud.sv
// rate generator: shift-mode phases and 16x oversample enables per direction
// assumes timer overflow pulses are one-cycle pulses on clk_i
`timescale 1ns/1ps
module fdsp_baud import fdsp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // configuration
   input wire logic [1:0] mode_i,
   input wire logic double_rate_i,
   input wire logic rx_src_t2_i,
   input wire logic tx_src_t2_i,
   input wire logic t1_ovf_i,
   input wire logic t2_ovf_i,
   // enables
   fdsp_tick_if.src tk
);
   logic [3:0] div_q;
   logic [1:0] pre_q;
   logic t1_half_q;
   logic fix_tick;
   logic t1_tick;
   logic [1:0] sel;
   logic [1:0] os;

   // ----------------------------------------
   // shift mode: one bit every twelve clocks
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || div_q == SHIFT_LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end
   assign tk.m0_fall = (div_q == '0);
   assign tk.m0_rise = (div_q == SHIFT_HALF);

   // ----------------------------------------
   // oversample sources
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         t1_half_q <= 1'b0;
      end else if (t1_ovf_i) begin
         t1_half_q <= ~t1_half_q;
      end
   end

   // 16 samples per bit: 64 or 32 clocks per bit in the fixed mode
   assign fix_tick = double_rate_i ? pre_q[0] : (pre_q == PRE_SLOW);
   // timer 1 rate is halved unless doubled; timer 2 overflow is the 16x rate
   assign t1_tick = t1_ovf_i && (double_rate_i || t1_half_q);
   assign sel = {tx_src_t2_i, rx_src_t2_i};

   for (genvar i = 0; i < 2; i++) begin : g_dir
      assign os[i] = (mode_i == MODE_FIX9) ? fix_tick : (sel[i] ? t2_ovf_i : t1_tick);
   end
   assign tk.rx_os = os[0];
   assign tk.tx_os = os[1];
endmodule

//--- hdl/fdsp_tx.sv
// transmit shifter for all four modes
// assumes start_i is a one-cycle pulse and mode is held during a frame
`timescale 1ns/1ps
module fdsp_tx import fdsp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // enables
   fdsp_tick_if.snk tk,
   // request
   input wire logic [1:0] mode_i,
   input wire logic start_i,
   input wire logic [7:0] data_i,
   input wire logic ninth_i,
   // line and status
   output logic line_o,
   output logic m0_clk_low_o,
   output logic busy_o,
   output logic ti_set_o
);
   logic [10:0] sh_q;
   logic [3:0] bit_q;
   logic [3:0] os_q;
   logic busy_q;
   logic low_q;
   logic ti_q;
   logic m0;

   assign m0 = (mode_i == MODE_SHIFT);

   // ----------------------------------------
   // shifter; a new write restarts the frame
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      ti_q <= 1'b0;
      if (sys_rst_i) begin
         sh_q <= '1;
         bit_q <= '0;
         os_q <= '0;
         busy_q <= 1'b0;
         low_q <= 1'b0;
      end else if (start_i) begin
         sh_q <= m0 ? {3'h7, data_i} : {1'b1, is_nine(mode_i) ? ninth_i : 1'b1, data_i, 1'b0};
         bit_q <= '0;
         os_q <= '0;
         busy_q <= 1'b1;
         low_q <= 1'b0;
      end else if (busy_q && m0) begin
         if (tk.m0_fall) begin
            low_q <= 1'b1;
         end else if (tk.m0_rise && low_q) begin
            low_q <= 1'b0;
            sh_q <= {1'b1, sh_q[10:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == BIT_LAST8) begin
               busy_q <= 1'b0;
               ti_q <= 1'b1;
            end
         end
      end else if (busy_q && tk.tx_os) begin
         os_q <= os_q + 4'h1;
         if (os_q == OS_LAST) begin
            sh_q <= {1'b1, sh_q[10:1]};
            bit_q <= bit_q + 4'h1;
            // flag raised as the stop bit goes out
            ti_q <= (bit_q + 4'h1 == stop_idx(mode_i));
            busy_q <= (bit_q != stop_idx(mode_i));
         end
      end
   end

   assign line_o = sh_q[0];
   assign m0_clk_low_o = low_q;
   assign busy_o = busy_q;
   assign ti_set_o = ti_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   tx_start_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && !m0 |=> !line_o && busy_o)
      else $error("async frame did not open with a zero start bit");
   tx_stop_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ti_set_o && !m0 && !$past(start_i) |-> line_o && busy_o)
      else $error("transmit flag not raised at the stop bit");
endmodule

//--- verif/fdsp_peer.sv
// remote serial party: async frame source and sink, shift-register source and sink
// assumes bit periods are given in system clock cycles and the line has a pull-up
`timescale 1ns/1ps
module fdsp_peer (
   // clock
   input wire logic clk_i,
   // line
   input wire logic txd_i,
   input wire logic rx_line_i,
   output logic rxd_o
);
   // ----------------------------------------
   // async frames
   // ----------------------------------------
   initial rxd_o = 1'b1;

   // v[8] is the ninth bit, or the stop bit when nb is 8
   task automatic send(input logic [8:0] v, input int nb, input int per);
      logic [10:0] f;
      f = {1'b1, v, 1'b0};
      @(negedge clk_i);
      for (int i = 0; i < nb + 2; i++) begin
         rxd_o = f[i];
         repeat (per) @(negedge clk_i);
      end
      rxd_o = 1'b1;
   endtask

   task automatic recv(input int nb, input int per, output logic [10:0] f);
      f = '0;
      @(negedge txd_i);
      // sample off the launching edge so the line is settled
      repeat (per / 2) @(negedge clk_i);
      for (int i = 0; i < nb + 2; i++) begin
         f[i] = txd_i;
         repeat (per) @(negedge clk_i);
      end
   endtask

   // ----------------------------------------
   // shift-register mode
   // ----------------------------------------
   // data changes on the clock's fall, so it is settled at each rise
   task automatic feed(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         rxd_o = d[i];
         @(posedge txd_i);
         if (i < 7) @(negedge txd_i);
      end
      rxd_o = 1'b1;
   endtask

   task automatic grab(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(negedge txd_i);
         d[i] = rx_line_i;
      end
   endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the full duplex serial port
// assumes the remote party model and timer pulses made here
`timescale 1ns/1ps
module tb_top import fdsp_pkg::*; ();
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic t1 = 1'b0;
   logic t2 = 1'b0;
   logic dr = 1'b0;
   logic rsel = 1'b0;
   logic tsel = 1'b0;
   logic tif, rif, rxd_out, oe_n, txd, peer_rxd, rx_line;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int tc = 0;

   always #12.5 clk_i = ~clk_i;
   assign rx_line = oe_n ? peer_rxd : rxd_out;

   fdsp_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr),
      .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .t1_ovf_i(t1), .t2_ovf_i(t2), .double_rate_bit_i(dr),
      .rx_clock_source_select_i(rsel), .tx_clock_source_select_i(tsel),
      .tx_complete_flag_o(tif), .rx_complete_flag_o(rif), .rxd_i(rx_line),
      .rxd_o(rxd_out), .rxd_oe_n_o(oe_n), .txd_o(txd));
   fdsp_peer i_peer (.clk_i(clk_i), .txd_i(txd), .rx_line_i(rx_line), .rxd_o(peer_rxd));

   // ----------------------------------------
   // timer pulses and run limit
   // ----------------------------------------
   // timer 1 every 2nd cycle, timer 2 every 3rd: two unequal rates
   always @(negedge clk_i) begin
      tc <= tc + 1;
      t1 <= (tc % 2 == 0);
      t2 <= (tc % 3 == 0);
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // access and checking
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge clk_i);
      wr_s = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      rd_s = 1'b1;
      @(negedge clk_i);
      rd_s = 1'b0;
      @(negedge clk_i);
      d = rdata;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      logic [7:0] r;
      logic [10:0] f;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      rd(SERIAL_CONTROL_STATUS_ADDR, r);
      chk("serial_control_status_reset", {8'h00, SERIAL_CONTROL_STATUS_RESET}, {8'h00, r});
      chk("txd_idle", 16'h0001, {15'h0, txd});
      rd(8'h9a, r);
      chk("unmapped_read", {8'h00, RD_NONE}, {8'h00, r});
      // fixed-rate 9-bit transmit at both rates, ninth bit both ways
      for (int d = 0; d < 2; d++) begin
         dr = d[0];
         wr(SERIAL_CONTROL_STATUS_ADDR, {4'h8, ~d[0], 3'h0});
         fork
            i_peer.recv(9, d ? 32 : 64, f);
            wr(SERIAL_DATA_LOCATION_ADDR, 8'ha5);
         join
         chk("m2_frame", {5'h0, 1'b1, ~d[0], 8'ha5, 1'b0}, {5'h0, f});
         chk("m2_tx_flag", 16'h0001, {15'h0, tif});
      end
      // 8-bit full duplex, receive and transmit on different sources
      for (int s = 0; s < 2; s++) begin
         dr = s[0];
         rsel = ~s[0];
         tsel = s[0];
         wr(SERIAL_CONTROL_STATUS_ADDR, 8'h50);
         fork
            i_peer.send(9'h13c, 8, s ? 32 : 48);
            i_peer.recv(8, s ? 48 : 64, f);
            wr(SERIAL_DATA_LOCATION_ADDR, 8'hc3);
         join
         chk("m1_tx_frame", 16'h0386, {5'h0, f});
         rd(SERIAL_CONTROL_STATUS_ADDR, r);
         chk("m1_serial_control_status", 16'h0057, {8'h00, r});
         rd(SERIAL_DATA_LOCATION_ADDR, r);
         chk("m1_rx_data", 16'h003c, {8'h00, r});
      end
      // second byte completes while first is unread
      i_peer.send(9'h177, 8, 32);
      repeat (8) @(negedge clk_i);
      rd(SERIAL_DATA_LOCATION_ADDR, r);
      chk("overrun_keep", 16'h003c, {8'h00, r});
      // multiprocessor filtering, 8-bit with bad stop then 9-bit
      wr(SERIAL_CONTROL_STATUS_ADDR, 8'h70);
      i_peer.send(9'h0ee, 8, 32);
      repeat (8) @(negedge clk_i);
      chk("m1_bad_stop", 16'h0000, {15'h0, rif});
      wr(SERIAL_CONTROL_STATUS_ADDR, 8'hf0);
      i_peer.send(9'h055, 9, 32);
      repeat (8) @(negedge clk_i);
      chk("m3_addr_zero", 16'h0000, {15'h0, rif});
      i_peer.send(9'h1aa, 9, 32);
      repeat (8) @(negedge clk_i);
      rd(SERIAL_CONTROL_STATUS_ADDR, r);
      chk("m3_serial_control_status", 16'h00f5, {8'h00, r});
      rd(SERIAL_DATA_LOCATION_ADDR, r);
      chk("m3_rx_data", 16'h00aa, {8'h00, r});
      // shift-register mode out, then in
      wr(SERIAL_CONTROL_STATUS_ADDR, 8'h00);
      fork
         i_peer.grab(r);
         wr(SERIAL_DATA_LOCATION_ADDR, 8'h96);
      join
      chk("m0_tx_data", 16'h0096, {8'h00, r});
      repeat (16) @(negedge clk_i);
      chk("m0_tx_flag", 16'h0001, {15'h0, tif});
      fork
         i_peer.feed(8'h5a);
         wr(SERIAL_CONTROL_STATUS_ADDR, 8'h10);
      join
      repeat (16) @(negedge clk_i);
      chk("m0_rx_flag", 16'h0001, {15'h0, rif});
      rd(SERIAL_DATA_LOCATION_ADDR, r);
      chk("m0_rx_data", 16'h005a, {8'h00, r});
      tally_and_finish();
   end
endmodule
